// *** rtl/gpx_pkg.sv ***
// Shared constants and types of the GPIO expander
package gpx_pkg;
   localparam int unsigned GPX_PORTS = 2;
   localparam int unsigned GPX_W = 8;
   localparam int unsigned GPX_IRQ_W = 3;
   // Fixed upper bits of the seven-bit target address
   localparam logic [3:0] GPX_ADDR_HI = 4'h4;
   // Command byte: bits [2:1] pick the register group, bit 0 the port
   localparam logic [1:0] GPX_GRP_IN = 2'h0;
   localparam logic [1:0] GPX_GRP_OUT = 2'h1;
   localparam logic [1:0] GPX_GRP_POL = 2'h2;
   localparam logic [1:0] GPX_GRP_CFG = 2'h3;
   // AHB-Lite byte offsets
   localparam logic [31:0] GPX_OFF_STAT = 32'h0000_0000;
   localparam logic [31:0] GPX_OFF_MASK = 32'h0000_0004;
   localparam logic [31:0] GPX_OFF_INPUT = 32'h0000_0008;
   localparam logic [31:0] GPX_OFF_CTRL = 32'h0000_000c;
   localparam int unsigned GPX_CTRL_EN_BIT = 0;
   localparam int unsigned GPX_CTRL_ADDR_LSB = 4;
   // Reset values
   localparam logic [7:0] GPX_CFG_RST = 8'hff;
   localparam logic [7:0] GPX_OUT_RST = 8'h00;
   localparam logic [7:0] GPX_POL_RST = 8'h00;
   localparam logic [2:0] GPX_MASK_RST = 3'h0;
   localparam logic GPX_EN_RST = 1'b1;
   // Start-up count until the pin synchroniser holds real levels
   localparam logic [1:0] GPX_PRIME_LOAD = 2'h2;
   localparam logic [1:0] GPX_PRIME_DONE = 2'h3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] ptr;
      logic [7:0] wdata;
   } gpx_i2c_req_t;
endpackage : gpx_pkg

// *** rtl/gpx_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module gpx_sync
   import gpx_pkg::*;
#(
   parameter int unsigned W = 1
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } gpx_sync_q_t;

   gpx_sync_q_t st_q;
   gpx_sync_q_t st_d;

   always_comb
   begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;

   property p_two_stage;
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn, 2) |-> q == $past(d, 2);
   endproperty
   a_two_stage: assert property (p_two_stage)
      else $error("synchroniser delay is not two cycles");
endmodule : gpx_sync

// *** rtl/gpx_i2c.sv ***
// I2C target engine: address match, command pointer, byte moves
`timescale 1ns/1ps
module gpx_i2c
   import gpx_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic enable,
   input wire logic [2:0] dev_addr,
   input wire logic [7:0] rd_byte,
   output gpx_i2c_req_t req,
   output logic sda_oe
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_WBYTE = 3'h2,
      ST_WACK = 3'h6,
      ST_RBYTE = 3'h7,
      ST_RACK = 3'h5
   } gpx_i2c_st_t;

   typedef struct packed {
      gpx_i2c_st_t st;
      logic [2:0] cnt;
      logic [7:0] shift;
      logic rw;
      logic first;
      logic drv;
      logic scl_p;
      logic sda_p;
      logic oe;
      logic [2:0] ptr;
      gpx_i2c_req_t req;
   } gpx_i2c_q_t;

   gpx_i2c_q_t q;
   gpx_i2c_q_t n;
   logic rise;
   logic fall;
   logic [7:0] byte_in;

   assign rise = scl && !q.scl_p;
   assign fall = !scl && q.scl_p;
   assign byte_in = {q.shift[6:0], sda};

   always_comb
   begin
      n = q;
      n.req.wr = 1'b0;
      n.req.rd = 1'b0;
      n.req.ptr = q.ptr;
      n.scl_p = scl;
      n.sda_p = sda;
      if (q.scl_p && scl && q.sda_p && !sda && enable)
      begin
         n.st = ST_ADDR;
         n.cnt = '0;
         n.oe = 1'b0;
      end
      else if (q.scl_p && scl && !q.sda_p && sda)
      begin
         n.st = ST_IDLE;
         n.oe = 1'b0;
      end
      else
      begin
         case (q.st)
            ST_ADDR:
            begin
               if (rise)
               begin
                  n.shift = byte_in;
                  n.cnt = q.cnt + 3'h1;
                  if (q.cnt == 3'h7)
                  begin
                     n.drv = 1'b0;
                     n.rw = sda;
                     n.st = (q.shift[6:0] == {GPX_ADDR_HI, dev_addr}) ?
                            ST_AACK : ST_IDLE;
                  end
               end
            end
            ST_AACK, ST_WACK:
            begin
               if (fall && !q.drv)
               begin
                  n.drv = 1'b1;
                  n.oe = 1'b1;
               end
               else if (fall)
               begin
                  n.drv = 1'b0;
                  n.cnt = '0;
                  n.first = (q.st == ST_AACK) ? 1'b1 : q.first;
                  if (q.st == ST_AACK && q.rw)
                  begin
                     n.shift = rd_byte;
                     n.oe = ~rd_byte[7];
                     n.req.rd = 1'b1;
                     n.st = ST_RBYTE;
                  end
                  else
                  begin
                     n.oe = 1'b0;
                     n.st = ST_WBYTE;
                  end
               end
            end
            ST_WBYTE:
            begin
               if (rise)
               begin
                  n.shift = byte_in;
                  n.cnt = q.cnt + 3'h1;
                  if (q.cnt == 3'h7)
                  begin
                     n.st = ST_WACK;
                     n.first = 1'b0;
                     n.ptr = q.first ? byte_in[2:0] : q.ptr ^ 3'h1;
                     n.req.wr = !q.first;
                     n.req.wdata = byte_in;
                  end
               end
            end
            ST_RBYTE:
            begin
               if (rise)
               begin
                  n.cnt = q.cnt + 3'h1;
                  n.st = (q.cnt == 3'h7) ? ST_RACK : ST_RBYTE;
               end
               else if (fall)
               begin
                  n.shift = {q.shift[6:0], 1'b0};
                  n.oe = ~q.shift[6];
               end
            end
            ST_RACK:
            begin
               if (rise)
               begin
                  n.drv = !sda;
                  n.ptr = sda ? q.ptr : q.ptr ^ 3'h1;
                  n.st = sda ? ST_IDLE : ST_RACK;
               end
               else if (fall && q.drv)
               begin
                  n.drv = 1'b0;
                  n.cnt = '0;
                  n.shift = rd_byte;
                  n.oe = ~rd_byte[7];
                  n.req.rd = 1'b1;
                  n.st = ST_RBYTE;
               end
               else if (fall)
               begin
                  n.oe = 1'b0;
               end
            end
            default:
            begin
               n.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign req = q.req;
   assign sda_oe = q.oe;

   property p_foreign_addr;
      @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_ADDR && rise && q.cnt == 3'h7 &&
       q.shift[6:0] != {GPX_ADDR_HI, dev_addr}) |=> q.st == ST_IDLE;
   endproperty
   a_foreign_addr: assert property (p_foreign_addr)
      else $error("target answered a foreign address");

   property p_sda_drive;
      @(posedge hclk) disable iff (!hresetn)
      q.oe |-> (q.st == ST_AACK || q.st == ST_WACK ||
                q.st == ST_RBYTE || q.st == ST_RACK);
   endproperty
   a_sda_drive: assert property (p_sda_drive)
      else $error("data line driven outside ack or read byte");
endmodule : gpx_i2c

// *** rtl/gpx_top.sv ***
// Sixteen-line GPIO expander top with AHB-Lite interrupt registers
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module gpx_top
   import gpx_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [7:0] port_zero_lines_i,
   output logic [7:0] port_zero_lines_o,
   output logic [7:0] port_zero_lines_oe,
   input wire logic [7:0] port_one_lines_i,
   output logic [7:0] port_one_lines_o,
   output logic [7:0] port_one_lines_oe,
   input wire logic addr_select_bit_zero,
   input wire logic addr_select_bit_one,
   input wire logic addr_select_bit_two,
   output logic alert_n_o,
   output logic alert_oe
);
   typedef logic [GPX_PORTS-1:0][GPX_W-1:0] gpx_bank_t;

   typedef struct packed {
      gpx_bank_t outv;
      gpx_bank_t pol;
      gpx_bank_t cfg;
      gpx_bank_t oe;
      gpx_bank_t snap;
      logic [1:0] prime;
      logic [GPX_PORTS-1:0] diff_p;
      logic [GPX_IRQ_W-1:0] stat;
      logic [GPX_IRQ_W-1:0] mask;
      logic en;
      logic dph;
      logic dwr;
      logic [31:0] daddr;
      logic [31:0] rdata;
      logic irq;
      logic alert_oe;
   } gpx_top_q_t;

   gpx_top_q_t q;
   gpx_top_q_t n;
   gpx_bank_t pins;
   logic scl_s;
   logic sda_s;
   logic [2:0] dev_addr;
   logic [GPX_PORTS-1:0] diff;
   logic [GPX_IRQ_W-1:0] ev;
   logic [GPX_IRQ_W-1:0] clr;
   logic ahb_go;
   logic [7:0] rd_byte;
   gpx_i2c_req_t req;

   // Register byte seen by the I2C target for a command pointer
   function automatic logic [7:0] reg_byte(
      input logic [2:0] ptr,
      input gpx_top_q_t s,
      input gpx_bank_t lv
   );
      logic [7:0] r;
      r = '0;
      if (ptr[2:1] == GPX_GRP_IN)
      begin
         r = lv[ptr[0]] ^ s.pol[ptr[0]];
      end
      else if (ptr[2:1] == GPX_GRP_OUT)
      begin
         r = s.outv[ptr[0]];
      end
      else if (ptr[2:1] == GPX_GRP_POL)
      begin
         r = s.pol[ptr[0]];
      end
      else
      begin
         r = s.cfg[ptr[0]];
      end
      return r;
   endfunction : reg_byte

   // AHB-Lite read decode; unmapped words read as zero
   function automatic logic [31:0] ahb_rd(
      input logic [31:0] a,
      input gpx_top_q_t s,
      input gpx_bank_t lv,
      input logic [2:0] da
   );
      logic [31:0] r;
      r = '0;
      if (a == GPX_OFF_STAT)
      begin
         r[GPX_IRQ_W-1:0] = s.stat;
      end
      else if (a == GPX_OFF_MASK)
      begin
         r[GPX_IRQ_W-1:0] = s.mask;
      end
      else if (a == GPX_OFF_INPUT)
      begin
         r[2*GPX_W-1:0] = lv ^ s.pol;
      end
      else if (a == GPX_OFF_CTRL)
      begin
         r[GPX_CTRL_EN_BIT] = s.en;
         r[GPX_CTRL_ADDR_LSB +: 3] = da;
      end
      return r;
   endfunction : ahb_rd

   gpx_sync #(
      .W(2 * GPX_W + 5)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({port_one_lines_i, port_zero_lines_i, scl_i, sda_i,
          addr_select_bit_two, addr_select_bit_one,
          addr_select_bit_zero}),
      .q({pins, scl_s, sda_s, dev_addr})
   );

   gpx_i2c u_i2c (
      .hclk(hclk),
      .hresetn(hresetn),
      .scl(scl_s),
      .sda(sda_s),
      .enable(q.en),
      .dev_addr(dev_addr),
      .rd_byte(rd_byte),
      .req(req),
      .sda_oe(sda_oe)
   );

   assign rd_byte = reg_byte(req.ptr, q, pins);

   genvar g;
   generate
      for (g = 0; g < GPX_PORTS; g++)
      begin : g_port
         assign diff[g] = (q.prime == GPX_PRIME_DONE) &&
                          |((pins[g] ^ q.snap[g]) & q.cfg[g]);
      end
   endgenerate

   assign ahb_go = hsel && htrans[1] && hready;
   assign ev = {req.wr, diff & ~q.diff_p};

   always_comb
   begin
      n = q;
      clr = '0;
      if (q.prime != GPX_PRIME_DONE)
      begin
         n.prime = q.prime + 2'h1;
         if (q.prime == GPX_PRIME_LOAD)
         begin
            n.snap = pins;
         end
      end
      if (req.wr && req.ptr[2:1] == GPX_GRP_OUT)
      begin
         n.outv[req.ptr[0]] = req.wdata;
      end
      else if (req.wr && req.ptr[2:1] == GPX_GRP_POL)
      begin
         n.pol[req.ptr[0]] = req.wdata;
      end
      else if (req.wr && req.ptr[2:1] == GPX_GRP_CFG)
      begin
         n.cfg[req.ptr[0]] = req.wdata;
      end
      n.oe = ~n.cfg;
      // snapshot only the port that was read
      if (req.rd && req.ptr[2:1] == GPX_GRP_IN)
      begin
         n.snap[req.ptr[0]] = pins[req.ptr[0]];
      end
      n.alert_oe = |diff;
      n.diff_p = diff;
      if (q.dph && q.dwr)
      begin
         if (q.daddr == GPX_OFF_STAT)
         begin
            clr = hwdata[GPX_IRQ_W-1:0];
         end
         else if (q.daddr == GPX_OFF_MASK)
         begin
            n.mask = hwdata[GPX_IRQ_W-1:0];
         end
         else if (q.daddr == GPX_OFF_CTRL)
         begin
            n.en = hwdata[GPX_CTRL_EN_BIT];
         end
      end
      // New events win over a clear in the same cycle
      n.stat = (q.stat & ~clr) | ev;
      n.irq = |(n.stat & n.mask);
      n.dph = ahb_go;
      n.dwr = hwrite;
      n.daddr = haddr;
      if (ahb_go && !hwrite)
      begin
         n.rdata = ahb_rd(haddr, n, pins, dev_addr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.cfg <= {GPX_PORTS{GPX_CFG_RST}};
         q.outv <= {GPX_PORTS{GPX_OUT_RST}};
         q.pol <= {GPX_PORTS{GPX_POL_RST}};
         q.mask <= GPX_MASK_RST;
         q.en <= GPX_EN_RST;
      end
      else
      begin
         q <= n;
      end
   end

   assign port_zero_lines_o = q.outv[0];
   assign port_zero_lines_oe = q.oe[0];
   assign port_one_lines_o = q.outv[1];
   assign port_one_lines_oe = q.oe[1];
   assign alert_oe = q.alert_oe;
   assign alert_n_o = 1'b0;
   assign sda_o = 1'b0;
   assign irq = q.irq;
   assign hrdata = q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_cfg_wr;
      req.wr && req.ptr[2:1] == GPX_GRP_CFG;
   endsequence

   sequence s_in_rd;
      req.rd && req.ptr[2:1] == GPX_GRP_IN;
   endsequence

   property p_reset_inputs;
      q.prime != GPX_PRIME_DONE |-> q.oe == '0 && q.cfg == '1;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs)
      else $error("a line is driven before configuration");

   property p_cfg_dir;
      s_cfg_wr |=> q.oe[$past(req.ptr[0])] == ~$past(req.wdata);
   endproperty
   a_cfg_dir: assert property (p_cfg_dir)
      else $error("direction does not follow config write");

   property p_out_latch;
      (req.wr && req.ptr[2:1] == GPX_GRP_OUT) |=>
         q.outv[$past(req.ptr[0])] == $past(req.wdata) ##1
         q.outv[$past(req.ptr[0], 2)] == $past(req.wdata, 2) ||
         $past(req.wr);
   endproperty
   a_out_latch: assert property (p_out_latch)
      else $error("output latch lost its value");

   property p_in_polarity;
      req.ptr[2:1] == GPX_GRP_IN |->
         rd_byte == (pins[req.ptr[0]] ^ q.pol[req.ptr[0]]);
   endproperty
   a_in_polarity: assert property (p_in_polarity)
      else $error("input byte ignores polarity");

   property p_readback;
      req.ptr[2:1] == GPX_GRP_CFG |-> rd_byte == q.cfg[req.ptr[0]];
   endproperty
   a_readback: assert property (p_readback)
      else $error("config byte not read back");

   property p_alert;
      (diff != '0) |=> q.alert_oe ##0 alert_oe;
   endproperty
   a_alert: assert property (p_alert)
      else $error("alert missing while an input differs");

   property p_release;
      s_in_rd |=> q.snap[$past(req.ptr[0])] == $past(pins[req.ptr[0]]);
   endproperty
   a_release: assert property (p_release)
      else $error("port read did not take a new snapshot");

   property p_out_quiet;
      (((pins ^ q.snap) & q.cfg) == '0) |=> !q.alert_oe;
   endproperty
   a_out_quiet: assert property (p_out_quiet)
      else $error("alert raised by an output line");

   property p_port_indep;
      s_in_rd |=> q.snap[!$past(req.ptr[0])] ==
                  $past(q.snap[!req.ptr[0]]);
   endproperty
   a_port_indep: assert property (p_port_indep)
      else $error("read of one port touched the other snapshot");

   property p_event_sticky;
      (diff[1] && !q.diff_p[1]) |=>
         q.stat[1] ##1 (q.stat[1] || $past(clr[1]));
   endproperty
   a_event_sticky: assert property (p_event_sticky)
      else $error("port one change not latched in status");
endmodule : gpx_top

// *** tb/gpx_i2c_host.sv ***
// I2C controller model that reaches the expander's target port
`timescale 1ns/1ps
module gpx_i2c_host
(
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // Bus idles with both lines released
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Line changes land on clock edges, so they go in late
   task automatic put(input logic b);
      #20 sda_low <= !b;
      #60 scl <= 1'b1;
      #80 scl <= 1'b0;
   endtask : put
   task automatic get(output logic b);
      sda_low <= 1'b0;
      #80 scl <= 1'b1;
      #60 b = sda;
      #20 scl <= 1'b0;
   endtask : get
   task automatic start();
      #80 sda_low <= 1'b1;
      #80 scl <= 1'b0;
   endtask : start
   task automatic stop();
      #20 sda_low <= 1'b1;
      #60 scl <= 1'b1;
      #80 sda_low <= 1'b0;
      #1300;
   endtask : stop
   // byte out, ack on ninth clock
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         put(v[i]);
      get(b);
      ack = !b;
   endtask : wbyte
   // byte in, nack ends the read
   task automatic rbyte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         get(v[i]);
      put(last);
   endtask : rbyte
   task automatic wr(input logic [6:0] dv, input logic [7:0] c,
      input logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      wbyte({dv, 1'b0}, a0);
      wbyte(c, a1);
      wbyte(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : wr
   task automatic rd(input logic [6:0] dv, input logic [7:0] c,
      output logic [7:0] v, output logic ok);
      logic a0, a1, a2;
      start();
      wbyte({dv, 1'b0}, a0);
      wbyte(c, a1);
      stop();
      start();
      wbyte({dv, 1'b1}, a2);
      rbyte(1'b1, v);
      stop();
      ok = a0 & a1 & a2;
   endtask : rd
endmodule : gpx_i2c_host

// *** tb/tb_top.sv ***
// Self-checking bench for the sixteen-line GPIO expander
`timescale 1ns/1ps
module tb_top
   import gpx_pkg::*;
;
   // straps held steady for the whole run
   localparam logic [2:0] STRAP = 3'h5;
   localparam logic [6:0] DEV = {GPX_ADDR_HI, STRAP};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic sda_o, sda_oe, alert_n_o, alert_oe, scl, host_low;
   logic [7:0] ext0, ext1, p0_o, p0_oe, p1_o, p1_oe;
   int bad_count, n_compared;
   wire logic sda = !(sda_oe | host_low);
   wire logic [7:0] pin0 = (p0_oe & p0_o) | (~p0_oe & ext0);
   wire logic [7:0] pin1 = (p1_oe & p1_o) | (~p1_oe & ext1);
   gpx_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .irq(irq), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .port_zero_lines_i(pin0), .port_zero_lines_o(p0_o),
      .port_zero_lines_oe(p0_oe), .port_one_lines_i(pin1),
      .port_one_lines_o(p1_o), .port_one_lines_oe(p1_oe),
      .addr_select_bit_zero(STRAP[0]), .addr_select_bit_one(STRAP[1]),
      .addr_select_bit_two(STRAP[2]), .alert_n_o(alert_n_o),
      .alert_oe(alert_oe));
   gpx_i2c_host i_host (.sda(sda), .scl(scl), .sda_low(host_low));
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic wr, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic alert_is(input logic v);
      int n;
      n = 0;
      while (alert_oe !== v && n < 30)
      begin
         @(posedge hclk);
         n++;
      end
      chk(alert_oe, v);
   endtask : alert_is
   task automatic t_reset();
      logic [31:0] r;
      logic [7:0] v;
      logic ok;
      chk(p0_oe, 0);
      chk(p1_oe, 0);
      chk({p1_o, p0_o}, 0);
      chk(alert_oe, 0);
      chk({hresp, sda_o, alert_n_o}, 0);
      ahb(1'b0, GPX_OFF_CTRL, 0, r);
      chk(r, {STRAP, 4'h1});
      ahb(1'b0, GPX_OFF_MASK, 0, r);
      chk(r, 0);
      ahb(1'b0, GPX_OFF_STAT, 0, r);
      chk(r, 0);
      ahb(1'b1, 32'h0000_0020, 32'hffff_ffff, r);
      ahb(1'b0, 32'h0000_0020, 0, r);
      chk(r, 0);
      i_host.rd(DEV, 8'h06, v, ok);
      chk({ok, v}, 9'h1ff);
      i_host.rd(DEV, 8'h05, v, ok);
      chk({ok, v}, 9'h100);
      $display("test reset done");
   endtask : t_reset
   task automatic t_addr();
      logic [31:0] r;
      logic ok;
      i_host.wr(DEV ^ 7'h01, 8'h06, 8'h00, ok);
      chk(ok, 0);
      chk(p0_oe, 0);
      ahb(1'b1, GPX_OFF_CTRL, 0, r);
      i_host.wr(DEV, 8'h06, 8'h00, ok);
      chk(ok, 0);
      chk(p0_oe, 0);
      ahb(1'b1, GPX_OFF_CTRL, 1, r);
      $display("test address done");
   endtask : t_addr
   task automatic t_dir();
      logic [7:0] v;
      logic ok;
      i_host.wr(DEV, 8'h06, 8'hf0, ok);
      chk(ok, 1);
      chk(p0_oe, 8'h0f);
      i_host.wr(DEV, 8'h02, 8'ha5, ok);
      chk(p0_o, 8'ha5);
      i_host.wr(DEV, 8'h03, 8'h3c, ok);
      chk({ok, p1_o, p1_oe}, 17'h13c00);
      repeat (30) @(posedge hclk);
      chk(alert_oe, 0);
      i_host.rd(DEV, 8'h02, v, ok);
      chk({ok, v}, 9'h1a5);
      i_host.rd(DEV, 8'h06, v, ok);
      chk({ok, v}, 9'h1f0);
      i_host.rd(DEV, 8'h00, v, ok);
      chk({ok, v}, 9'h105);
      $display("test direction done");
   endtask : t_dir
   task automatic t_alert();
      logic [31:0] r;
      logic [7:0] v;
      logic ok;
      i_host.wr(DEV, 8'h05, 8'hff, ok);
      ahb(1'b1, GPX_OFF_STAT, 32'h7, r);
      @(posedge hclk);
      ext1 <= 8'h3c;
      repeat (2) @(posedge hclk);
      chk(alert_oe, 0);
      alert_is(1'b1);
      ahb(1'b0, GPX_OFF_INPUT, 0, r);
      chk(r[15:8], 8'hc3);
      ahb(1'b0, GPX_OFF_STAT, 0, r);
      chk(r, 32'h2);
      chk(irq, 0);
      ahb(1'b1, GPX_OFF_MASK, 32'h2, r);
      repeat (3) @(posedge hclk);
      chk(irq, 1);
      i_host.rd(DEV, 8'h00, v, ok);
      chk(alert_oe, 1);
      i_host.rd(DEV, 8'h01, v, ok);
      chk({ok, v}, 9'h1c3);
      alert_is(1'b0);
      ahb(1'b1, GPX_OFF_STAT, 32'h2, r);
      repeat (3) @(posedge hclk);
      chk(irq, 0);
      @(posedge hclk);
      ext1 <= 8'h00;
      alert_is(1'b1);
      @(posedge hclk);
      ext1 <= 8'h3c;
      alert_is(1'b0);
      chk(irq, 1);
      ahb(1'b1, GPX_OFF_MASK, 0, r);
      repeat (3) @(posedge hclk);
      chk(irq, 0);
      $display("test alert done");
   endtask : t_alert
   initial
   begin
      bad_count = 0;
      n_compared = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      ext0 = 8'h00;
      ext1 = 8'h00;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      t_reset();
      t_addr();
      t_dir();
      t_alert();
      complete_run();
   end
   // Tests need about 100 us; six times that means a hang
   initial
   begin
      #600_000;
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, 1'b0, 1'b1);
      complete_run();
   end
endmodule : tb_top
